/* hw/cbs_consts.vh */
`ifndef CBS_CONSTS_VH
`define CBS_CONSTS_VH

// Register addresses on the serial configuration port.
`define CBS_ADDR_CTRL 5'h00
`define CBS_ADDR_STATUS 5'h01
`define CBS_ADDR_BANK_A 5'h08
`define CBS_ADDR_BANK_B 5'h0C
`define CBS_BANK_BYTES 4

// Command byte layout.
`define CBS_CMD_WRITE_BIT 7
`define CBS_CMD_COUNT_HI 6
`define CBS_CMD_COUNT_LO 5
`define CBS_CMD_ADDR_HI 4
`define CBS_CMD_ADDR_LO 0

// Control register fields and reset value.
`define CBS_CTRL_FIRST_BIT 0
`define CBS_CTRL_SECOND_BIT 1
`define CBS_CTRL_LNA_BIT 2
`define CBS_CTRL_RESET 8'h01

// Bank selection codes formed as {second_set_select, first_set_select}.
`define CBS_SEL_PIN 2'h0
`define CBS_SEL_A 2'h1
`define CBS_SEL_B 2'h2
`define CBS_SEL_ALT 2'h3

// Timing.
`define CBS_CLK_HZ 40000000
`define CBS_REF_CLK_HZ 300000
`define CBS_REF_HALF_CYCLES (`CBS_CLK_HZ / (2 * `CBS_REF_CLK_HZ))
`define CBS_STROBE_PERIOD_US 1000
`define CBS_STROBE_CYCLES (`CBS_STROBE_PERIOD_US * (`CBS_CLK_HZ / 1000000))

`endif

/* hw/cbs_spi_slave.v */
`timescale 1ns/100ps
`include "cbs_consts.vh"

module cbs_spi_slave (
  input wire clk,
  input wire rstn,
  input wire config_select_n,
  input wire sclk,
  input wire mosi,
  input wire [7:0] tx_data,
  input wire tx_enable,
  output reg [7:0] rx_byte,
  output reg rx_valid,
  output reg rx_first,
  output reg active,
  output wire miso,
  output wire miso_oe
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [1:0] cs_sync;
  reg [1:0] sclk_sync;
  reg [1:0] mosi_sync;
  reg sclk_prev;
  reg [2:0] bit_count;
  reg [6:0] shift_in;
  reg [7:0] shift_out;
  reg first_pending;
  reg load_pending;
  wire sclk_rise;
  wire sclk_fall;

  assign sclk_rise = sclk_sync[1] & ~sclk_prev;
  assign sclk_fall = ~sclk_sync[1] & sclk_prev;
  assign miso = shift_out[7];
  assign miso_oe = active & tx_enable;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_sync <= 2'h3;
      sclk_sync <= 2'h0;
      mosi_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], config_select_n};
      sclk_sync <= {sclk_sync[0], sclk};
      mosi_sync <= {mosi_sync[0], mosi};
      sclk_prev <= sclk_sync[1];
    end
  end

  // ****************************************
  // Byte framing
  // ****************************************
  // A falling select restarts framing so the next byte is the command.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active <= 1'b0;
      bit_count <= 3'h0;
      shift_in <= 7'h00;
      shift_out <= 8'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      first_pending <= 1'b0;
      load_pending <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (cs_sync[1]) begin
        active <= 1'b0;
        bit_count <= 3'h0;
        shift_out <= 8'h00;
        load_pending <= 1'b0;
      end else begin
        if (!active) begin
          active <= 1'b1;
          first_pending <= 1'b1;
          bit_count <= 3'h0;
        end else if (sclk_rise) begin
          bit_count <= bit_count + 3'h1;
          shift_in <= {shift_in[5:0], mosi_sync[1]};
          if (bit_count == 3'h7) begin
            rx_byte <= {shift_in, mosi_sync[1]};
            rx_valid <= 1'b1;
            rx_first <= first_pending;
            first_pending <= 1'b0;
            load_pending <= 1'b1;
          end
        end else if (sclk_fall && load_pending) begin
          // The next register is loaded on the falling edge that closes a byte.
          // Loading earlier would overwrite the last bit while the host still
          // samples it, and by this edge the register pointer has moved.
          shift_out <= tx_data;
          load_pending <= 1'b0;
        end else if (sclk_fall && bit_count != 3'h0) begin
          shift_out <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end

endmodule // cbs_spi_slave

/* hw/cbs_bank_switch.v */
// Functional notes
// RL1: Two independent configuration sets, bank A and bank B, are held.
// RL2: Select bits choose bank A, bank B, or periodic alternation without host.
// RL3: Internal strobe oscillator timing swaps the active bank.
// RL4: The host strobe pin steers bank selection and the device follows it.
// RL5: Serial writes to the two select bits apply a new bank selection.
// RL6: Log-amplifier strength sits in the low four status bits.
// RL7: LNA gain control level sits in the high four status bits.
// RL8: Sampling control input decides when strength values are sampled.
// RL9: LNA drive pin follows the switch level register bit.
// RL10: Reference clock near 300 kHz is divided from the main clock.
// RL11: Each serial access opens with a command byte after select falls.
// RL12: Alternation swaps banks only at strobe cycle boundaries; the code also swaps on a host strobe pin rising edge.

`timescale 1ns/100ps
`include "cbs_consts.vh"

module cbs_bank_switch #(
  parameter STROBE_CYCLES = `CBS_STROBE_CYCLES
) (
  input wire clk,
  input wire rstn,
  input wire config_select_n,
  input wire sclk,
  input wire mosi,
  output wire miso,
  output wire miso_oe,
  input wire strobe_pin,
  input wire strength_sample_control,
  input wire [3:0] log_amp_level,
  input wire [3:0] lna_gain_level,
  output reg lna_switch_out,
  output reg reference_clock_out,
  output reg active_bank_b,
  output reg strobe_boundary,
  output reg [31:0] active_config
);

  // ****************************************
  // Serial port
  // ****************************************
  wire [7:0] rx_byte;
  wire rx_valid;
  wire rx_first;
  wire spi_active;
  reg [7:0] tx_data;
  reg cmd_write;
  reg cmd_read;
  reg [2:0] remaining;
  reg [4:0] pointer;
  reg [7:0] ctrl;
  reg [7:0] signal_strength_status;
  reg [7:0] bank_mem [0:2*`CBS_BANK_BYTES-1];
  wire [1:0] count_field;

  cbs_spi_slave u_spi (
    .clk(clk),
    .rstn(rstn),
    .config_select_n(config_select_n),
    .sclk(sclk),
    .mosi(mosi),
    .tx_data(tx_data),
    .tx_enable(cmd_read),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .rx_first(rx_first),
    .active(spi_active),
    .miso(miso),
    .miso_oe(miso_oe)
  );

  assign count_field = rx_byte[`CBS_CMD_COUNT_HI:`CBS_CMD_COUNT_LO];

  // Read data for the current pointer; unmapped addresses read zero.
  always @* begin
    tx_data = 8'h00;
    if (pointer == `CBS_ADDR_CTRL) begin
      tx_data = ctrl;
    end else if (pointer == `CBS_ADDR_STATUS) begin
      tx_data = signal_strength_status;
    end else if (pointer[4:3] == 2'h1) begin
      tx_data = bank_mem[pointer[2:0]];
    end
  end

  // ****************************************
  // Command and register writes
  // ****************************************
  // A count field of zero means four registers, so the field always covers 1..4.
  integer i;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_write <= 1'b0;
      cmd_read <= 1'b0;
      remaining <= 3'h0;
      pointer <= 5'h00;
      ctrl <= `CBS_CTRL_RESET;
      for (i = 0; i < 2*`CBS_BANK_BYTES; i = i + 1) begin
        bank_mem[i] <= 8'h00;
      end
    end else if (!spi_active) begin
      cmd_write <= 1'b0;
      cmd_read <= 1'b0;
    end else if (rx_valid && rx_first) begin
      cmd_write <= rx_byte[`CBS_CMD_WRITE_BIT]; // see RL11
      cmd_read <= ~rx_byte[`CBS_CMD_WRITE_BIT];
      remaining <= (count_field == 2'h0) ? 3'h4 : {1'b0, count_field};
      pointer <= rx_byte[`CBS_CMD_ADDR_HI:`CBS_CMD_ADDR_LO];
    end else if (rx_valid && remaining != 3'h0) begin
      remaining <= remaining - 3'h1;
      pointer <= pointer + 5'h01;
      if (cmd_write) begin
        if (pointer == `CBS_ADDR_CTRL) begin
          ctrl <= rx_byte; // see RL5
        end else if (pointer[4:3] == 2'h1) begin
          bank_mem[pointer[2:0]] <= rx_byte; // see RL1
        end
      end
    end else if (rx_valid) begin
      cmd_write <= 1'b0;
      cmd_read <= 1'b0;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [1:0] strobe_sync;
  reg [1:0] sample_sync;
  reg [3:0] log_sync0;
  reg [3:0] log_sync1;
  reg [3:0] gain_sync0;
  reg [3:0] gain_sync1;
  reg strobe_prev;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_sync <= 2'h0;
      sample_sync <= 2'h0;
      log_sync0 <= 4'h0;
      log_sync1 <= 4'h0;
      gain_sync0 <= 4'h0;
      gain_sync1 <= 4'h0;
      strobe_prev <= 1'b0;
    end else begin
      strobe_sync <= {strobe_sync[0], strobe_pin};
      sample_sync <= {sample_sync[0], strength_sample_control};
      log_sync0 <= log_amp_level;
      log_sync1 <= log_sync0;
      gain_sync0 <= lna_gain_level;
      gain_sync1 <= gain_sync0;
      strobe_prev <= strobe_sync[1];
    end
  end

  // ****************************************
  // Strobe oscillator and bank selection
  // ****************************************
  reg [31:0] strobe_count;
  wire [1:0] select;
  wire pin_rise;

  assign select = {ctrl[`CBS_CTRL_SECOND_BIT], ctrl[`CBS_CTRL_FIRST_BIT]};
  assign pin_rise = strobe_sync[1] & ~strobe_prev;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_count <= 32'h00000000;
      strobe_boundary <= 1'b0;
    end else if (strobe_count == STROBE_CYCLES - 1) begin
      strobe_count <= 32'h00000000;
      strobe_boundary <= 1'b1; // see RL3
    end else begin
      strobe_count <= strobe_count + 32'h00000001;
      strobe_boundary <= 1'b0;
    end
  end

  // In alternation a host strobe rising edge also swaps the bank, but it does not
  // restart the strobe counter, so only the swap rule is shared by both sources.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_bank_b <= 1'b0;
    end else begin
      case (select)
        `CBS_SEL_A: active_bank_b <= 1'b0; // see RL2
        `CBS_SEL_B: active_bank_b <= 1'b1; // see RL2
        `CBS_SEL_ALT: begin
          if (strobe_boundary || pin_rise) begin
            active_bank_b <= ~active_bank_b; // see RL12
          end
        end
        default: active_bank_b <= strobe_sync[1]; // see RL4
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < `CBS_BANK_BYTES; g = g + 1) begin : g_cfg
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          active_config[8*g+7:8*g] <= 8'h00;
        end else begin
          active_config[8*g+7:8*g] <= bank_mem[active_bank_b ? (g + `CBS_BANK_BYTES) : g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Strength status, LNA pin, reference clock
  // ****************************************
  reg [7:0] ref_count;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      signal_strength_status <= 8'h00;
      lna_switch_out <= 1'b0;
      ref_count <= 8'h00;
      reference_clock_out <= 1'b0;
    end else begin
      // Holding while the control is low keeps a stable value for readback.
      if (sample_sync[1]) begin // see RL8
        signal_strength_status <= {gain_sync1, log_sync1}; // see RL6 see RL7
      end
      lna_switch_out <= ctrl[`CBS_CTRL_LNA_BIT]; // see RL9
      if (ref_count == `CBS_REF_HALF_CYCLES - 1) begin
        ref_count <= 8'h00;
        reference_clock_out <= ~reference_clock_out; // see RL10
      end else begin
        ref_count <= ref_count + 8'h01;
      end
    end
  end

endmodule // cbs_bank_switch

/* tb/cbs_bank_switch_properties.sv */
`timescale 1ns/100ps
module cbs_bank_switch_checker #(
  parameter int STROBE_CYCLES = 16
) (
  input wire clk,
  input wire rstn,
  input wire config_select_n,
  input wire sclk,
  input wire mosi,
  input wire miso,
  input wire miso_oe,
  input wire strobe_pin,
  input wire strength_sample_control,
  input wire [3:0] log_amp_level,
  input wire [3:0] lna_gain_level,
  input wire lna_switch_out,
  input wire reference_clock_out,
  input wire active_bank_b,
  input wire strobe_boundary,
  input wire [31:0] active_config
);
  // Cycles since the serial select last sat low; writes land within a few cycles of it.
  reg [3:0] quiet_cnt;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) quiet_cnt <= 4'h0;
    else if (!config_select_n) quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hF) quiet_cnt <= quiet_cnt + 4'h1;
  end
  // Cycles since the previous boundary pulse, so the first period after reset is checked too.
  int since_strobe;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) since_strobe <= 0;
    else if (strobe_boundary) since_strobe <= 1;
    else since_strobe <= since_strobe + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // The select is seen through two flip-flops, so the drive may linger three cycles.
  a_oe_needs_select: assert property (miso_oe |-> !$past(config_select_n, 3))
    else $error("miso driven while deselected");
  a_cmd_byte_first: assert property ($fell(config_select_n) |-> !miso_oe [*8])
    else $error("miso driven before the command byte");
  a_strobe_single: assert property (strobe_boundary |=> !strobe_boundary)
    else $error("strobe boundary wider than one cycle");
  a_strobe_period: assert property (strobe_boundary ? since_strobe == STROBE_CYCLES :
    since_strobe < STROBE_CYCLES) else $error("strobe boundary period wrong");
  a_ref_half_period: assert property ($changed(reference_clock_out) |-> ##66
    $changed(reference_clock_out)) else $error("reference clock half period wrong");
  a_ref_clock_hold: assert property ($changed(reference_clock_out) |=>
    $stable(reference_clock_out) [*8]) else $error("reference clock glitch");
  a_lna_needs_write: assert property ($changed(lna_switch_out) |-> quiet_cnt < 4'hC)
    else $error("lna drive moved without a write");
  a_cfg_tracks_bank: assert property ((quiet_cnt > 4'h8 && $stable(active_bank_b)) |=>
    $stable(active_config)) else $error("active config moved without a bank change");
  c_bank_swap: cover property ($changed(active_bank_b));
  c_read_drive: cover property (miso_oe);
  c_lna_on: cover property ($rose(lna_switch_out));
endmodule // cbs_bank_switch_checker
bind cbs_bank_switch cbs_bank_switch_checker #(.STROBE_CYCLES(STROBE_CYCLES)) checker_inst (
  .clk, .rstn, .config_select_n, .sclk, .mosi, .miso, .miso_oe, .strobe_pin,
  .strength_sample_control, .log_amp_level, .lna_gain_level, .lna_switch_out,
  .reference_clock_out, .active_bank_b, .strobe_boundary, .active_config);

/* tb/cbs_host_model.sv */
`timescale 1ns/100ps
module cbs_host_model (
  input wire clk,
  output reg config_select_n,
  output reg sclk,
  output reg mosi,
  input wire miso,
  input wire miso_oe
);
  initial begin
    config_select_n = 1'h1;
    sclk = 1'h0;
    mosi = 1'h0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic open_access;
    gap(8);
    config_select_n = 1'h0;
    gap(8);
  endtask
  // A released MOSI shows the inverse of its last bit so no stale value is trusted.
  task automatic close_access;
    gap(8);
    config_select_n = 1'h1;
    mosi = ~mosi;
    gap(8);
  endtask
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      gap(8);
      sclk = 1'h1;
      gap(8);
      rx[i] = miso_oe ? miso : 1'hx;
      sclk = 1'h0;
    end
  endtask
endmodule // cbs_host_model

/* tb/tb.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module tb;
  reg clk, rstn, strobe_pin, strength_sample_control;
  reg [3:0] log_amp_level, lna_gain_level;
  wire config_select_n, sclk, mosi, miso, miso_oe;
  wire lna_switch_out, reference_clock_out, active_bank_b, strobe_boundary;
  wire [31:0] active_config;
  int fails = 0, checks_done = 0, cycles = 0, n;
  logic [7:0] rd;
  logic b;
  // Each row is {ctrl, strobe pin, expected bank, expected lna drive}.
  logic [10:0] rows [6] = '{{8'h01, 3'h4}, {8'h02, 3'h2}, {8'h00, 3'h6}, {8'h00, 3'h0},
    {8'h05, 3'h5}, {8'h06, 3'h3}};
  cbs_bank_switch #(.STROBE_CYCLES(16)) cbs_bank_switch_inst (.clk, .rstn, .config_select_n,
    .sclk, .mosi, .miso, .miso_oe, .strobe_pin, .strength_sample_control, .log_amp_level,
    .lna_gain_level, .lna_switch_out, .reference_clock_out, .active_bank_b, .strobe_boundary,
    .active_config);
  cbs_host_model cbs_host_model_inst (.clk, .config_select_n, .sclk, .mosi, .miso, .miso_oe);
  task automatic xfer(input logic [7:0] cmd, input logic [39:0] d, input int k);
    cbs_host_model_inst.open_access;
    cbs_host_model_inst.shift_byte(cmd, rd);
    for (int i = 0; i < k; i++) cbs_host_model_inst.shift_byte(d[39-8*i -: 8], rd);
    cbs_host_model_inst.close_access;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    rstn = 1'h0;
    strobe_pin = 1'h0;
    strength_sample_control = 1'h1;
    log_amp_level = 4'h5;
    lna_gain_level = 4'hA;
    repeat (2) @(posedge clk);
    #1 rstn = 1'h1;
    `CHK("reset_bank", 1'h0, active_bank_b)
    `CHK("reset_lna", 1'h0, lna_switch_out)
    xfer(8'h20, 40'h0, 1);
    `CHK("reset_ctrl", 8'h01, rd)
    $display("test reset done");
    xfer(8'h8C, 40'h5566778800, 4);
    xfer(8'h88, 40'h11223344EE, 5);
    foreach (rows[i]) begin
      strobe_pin = rows[i][2];
      xfer({3'h5, 5'h00}, {rows[i][10:3], 32'h0}, 1);
      `CHK("bank", rows[i][1], active_bank_b)
      `CHK("lna", rows[i][0], lna_switch_out)
      `CHK("config", rows[i][1] ? 32'h88776655 : 32'h44332211, active_config)
      xfer(8'h20, 40'h0, 1);
      `CHK("ctrl", rows[i][10:3], rd)
    end
    $display("test table done");
    xfer(8'hA0, 40'h0300000000, 1);
    repeat (2) begin
      do begin
        @(posedge clk);
        #1;
      end while (!strobe_boundary);
      b = active_bank_b;
      @(posedge clk);
      #1;
      `CHK("alt_swap", ~b, active_bank_b)
      repeat (8) @(posedge clk);
      #1;
      `CHK("alt_hold", ~b, active_bank_b)
    end
    // A host strobe edge between two boundaries also swaps the bank.
    b = active_bank_b;
    strobe_pin = 1'h1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("alt_pin", ~b, active_bank_b)
    $display("test alternate done");
    xfer(8'h21, 40'h0, 1);
    `CHK("status_live", 8'hA5, rd)
    strength_sample_control = 1'h0;
    repeat (4) @(posedge clk);
    #1 log_amp_level = 4'h3;
    lna_gain_level = 4'hC;
    xfer(8'hA1, 40'hFF00000000, 1);
    xfer(8'h21, 40'h0, 1);
    `CHK("status_held", 8'hA5, rd)
    strength_sample_control = 1'h1;
    xfer(8'h21, 40'h0, 1);
    `CHK("status_new", 8'hC3, rd)
    xfer(8'h25, 40'h0, 1);
    `CHK("unmapped", 8'h00, rd)
    $display("test status done");
    @(posedge reference_clock_out);
    n = cycles;
    @(posedge reference_clock_out);
    `CHK("ref_period", 132, cycles - n)
    $display("test refclk done");
    close_out;
  end
endmodule // tb
